//--- crf_defines.svh
// crf_defines.svh: offsets, field positions, reset values for the core state block
// assumes inclusion by bare name from the package and the design modules
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// status register bit positions
`define CRF_FLAG_C        0
`define CRF_FLAG_Z        1
`define CRF_FLAG_N        2
`define CRF_FLAG_V        3
`define CRF_FLAG_S        4
`define CRF_FLAG_H        5
`define CRF_FLAG_T        6
`define CRF_FLAG_I        7
`define CRF_FLAGS_RESET   8'h00

// io space offsets of the stack pointer bytes and status register
`define CRF_IO_SP_LOW     6'h3d
`define CRF_IO_SP_HIGH    6'h3e
`define CRF_IO_FLAGS      6'h3f

// data space window of the working registers and pointer pairs
`define CRF_REG_LAST      5'h1f
`define CRF_PTR_X_LOW     5'h1a
`define CRF_PTR_Y_LOW     5'h1c
`define CRF_PTR_Z_LOW     5'h1e

// vector table
`define CRF_RESET_VECTOR  16'h0000
`define CRF_VECTOR_STEP   16'h0002

`endif

//--- crf_pkg.sv
// crf_pkg.sv: types shared by the core state block and its pointer unit
// assumes crf_defines.svh on the include path
`include "crf_defines.svh"

package crf_pkg;

    // register file port scheme
    typedef enum logic [3:0] {
        CRF_ACC_R1W1   = 4'b0001,
        CRF_ACC_R2W1   = 4'b0010,
        CRF_ACC_R2W16  = 4'b0100,
        CRF_ACC_R16W16 = 4'b1000
    } crf_access_t;

    // stack pointer operation
    typedef enum logic [5:0] {
        CRF_SP_NONE = 6'b000001,
        CRF_SP_PUSH = 6'b000010,
        CRF_SP_POP  = 6'b000100,
        CRF_SP_CALL = 6'b001000,
        CRF_SP_RET  = 6'b010000,
        CRF_SP_IRQ_RETURN = 6'b100000
    } crf_spop_t;

    // pointer addressing mode
    typedef enum logic [3:0] {
        CRF_PM_NONE = 4'b0001,
        CRF_PM_DISP = 4'b0010,
        CRF_PM_INC  = 4'b0100,
        CRF_PM_DEC  = 4'b1000
    } crf_ptrmode_t;

    // flag results from the alu
    typedef struct packed {
        logic update_h;
        logic update_v;
        logic update_n;
        logic update_z;
        logic update_c;
        logic half;
        logic ovf;
        logic neg;
        logic zero;
        logic carry;
    } crf_flag_in_t;

    // register file request
    typedef struct packed {
        crf_access_t scheme;
        logic        wr_en;
        logic [4:0]  rd_a;
        logic [4:0]  rd_b;
        logic [4:0]  wr_addr;
        logic [15:0] wr_data;
    } crf_rf_req_t;

    // pointer request
    typedef struct packed {
        crf_ptrmode_t mode;
        logic [1:0]   sel;
        logic [5:0]   disp;
    } crf_ptr_req_t;

endpackage

//--- crf_ptr_unit.sv
// crf_ptr_unit.sv: effective address and updated pair for one indirect pointer
// assumes the caller supplies the current pair and writes back the update
`timescale 1ns/100ps
`include "crf_defines.svh"

module crf_ptr_unit (
    input  wire crf_pkg::crf_ptrmode_t mode,
    input  wire logic [15:0]           ptr_cur,
    input  wire logic [5:0]            disp,
    output logic [15:0]                eff_addr,
    output logic [15:0]                ptr_new,
    output logic                       ptr_wr
);
    wire logic [15:0] ptr_inc;
    wire logic [15:0] ptr_dec;
    wire logic [15:0] ptr_disp;

    // candidate addresses
    assign ptr_inc  = ptr_cur + 16'h0001;
    assign ptr_dec  = ptr_cur - 16'h0001;
    assign ptr_disp = ptr_cur + {10'h000, disp};

    // post increment, pre decrement, displacement leaves pair alone
    assign eff_addr = (mode == crf_pkg::CRF_PM_DEC)  ? ptr_dec  :
                      (mode == crf_pkg::CRF_PM_DISP) ? ptr_disp : ptr_cur;
    assign ptr_new  = (mode == crf_pkg::CRF_PM_DEC)  ? ptr_dec  : ptr_inc;
    assign ptr_wr   = (mode == crf_pkg::CRF_PM_INC) || (mode == crf_pkg::CRF_PM_DEC);
endmodule

//--- crf_core_state.sv
// crf_core_state.sv: status flags, working registers, pointers, stack pointer, interrupt gate
// assumes the alu and execute pipeline share SYS_CLK and drive requests one per cycle
`timescale 1ns/100ps
`include "crf_defines.svh"

module crf_core_state #(
    parameter int          SP_BITS   = 11,
    parameter logic [15:0] LAST_SRAM = 16'h04ff,
    parameter int          IRQ_NUM   = 8
) (
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST_B,
    input  wire crf_pkg::crf_rf_req_t   RF_REQ,
    output logic [15:0]                 RF_OPA,
    output logic [7:0]                  RF_OPB,
    input  wire crf_pkg::crf_flag_in_t  FLAG_IN,
    input  wire logic                   FLAG_T_WR,
    input  wire logic                   FLAG_T_VAL,
    input  wire logic                   GIE_SET,
    input  wire logic                   GIE_CLR,
    input  wire crf_pkg::crf_ptr_req_t  PTR_REQ,
    output logic [15:0]                 PTR_ADDR,
    input  wire logic                   DS_WR,
    input  wire logic                   DS_RD,
    input  wire logic [15:0]            DS_ADDR,
    input  wire logic [7:0]             DS_WDATA,
    output logic [7:0]                  DS_RDATA,
    output logic                        DS_HIT,
    input  wire crf_pkg::crf_spop_t     SP_OP,
    output logic [15:0]                 STACK_PTR,
    input  wire logic [IRQ_NUM-1:0]     IRQ_PEND,
    input  wire logic [IRQ_NUM-1:0]     IRQ_EN,
    input  wire logic                   IRQ_ACK,
    output logic                        IRQ_TAKE,
    output logic [15:0]                 IRQ_VECTOR,
    output logic [7:0]                  FLAGS_OUT,
    input  wire logic [15:0]            FETCH_WORD,
    input  wire logic                   FETCH_VALID,
    output logic [15:0]                 EXEC_WORD
);
    localparam logic [15:0] SP_MASK = 16'((32'h1 << SP_BITS) - 32'h1);
    localparam bit          HAS_SPH = (SP_BITS > 8);

    // storage
    logic [7:0]  regs_r [0:31];
    logic [7:0]  flags_r;
    logic [7:0]  flags_nxt;
    logic [15:0] sp_r;
    logic [15:0] sp_nxt;
    logic [15:0] exec_r;
    logic [15:0] opa_r;
    logic [7:0]  opb_r;
    logic [7:0]  ds_rdata_r;
    logic        ds_hit_r;
    logic [15:0] ptr_addr_r;
    logic        irq_take_r;
    logic [15:0] irq_vec_r;

    // decode wires
    wire logic        rf_wide_wr;
    wire logic        ds_in_rf;
    wire logic        ds_sp_lo;
    wire logic        ds_sp_hi;
    wire logic        ds_flags;
    wire logic [4:0]  ptr_lo_idx;
    wire logic [15:0] ptr_cur;
    wire logic [15:0] ptr_new;
    wire logic        ptr_wr;
    wire logic [15:0] eff_addr;
    wire logic [15:0] sp_step;
    wire logic        sp_dn;
    wire logic        sp_up;
    wire logic [IRQ_NUM-1:0] irq_live;
    wire logic        irq_any;
    logic [15:0]      irq_idx;
    wire logic [4:0]  rd_a_hi;
    wire logic [4:0]  rf_wr_hi;

    // register file access scheme decode
    assign rf_wide_wr = (RF_REQ.scheme == crf_pkg::CRF_ACC_R2W16) ||
                        (RF_REQ.scheme == crf_pkg::CRF_ACC_R16W16);
    assign rd_a_hi    = RF_REQ.rd_a | 5'h01;
    assign rf_wr_hi   = RF_REQ.wr_addr | 5'h01;

    // data space decode: registers first, io window at 0x20 offset
    assign ds_in_rf = (DS_ADDR[15:5] == 11'h000);
    assign ds_sp_lo = (DS_ADDR == {10'h000, `CRF_IO_SP_LOW} + 16'h0020);
    assign ds_sp_hi = HAS_SPH && (DS_ADDR == {10'h000, `CRF_IO_SP_HIGH} + 16'h0020);
    assign ds_flags = (DS_ADDR == {10'h000, `CRF_IO_FLAGS} + 16'h0020);

    // pointer pair selection
    assign ptr_lo_idx = (PTR_REQ.sel == 2'd0) ? `CRF_PTR_X_LOW :
                        (PTR_REQ.sel == 2'd1) ? `CRF_PTR_Y_LOW : `CRF_PTR_Z_LOW;
    assign ptr_cur    = {regs_r[ptr_lo_idx | 5'h01], regs_r[ptr_lo_idx]};

    crf_ptr_unit u_ptr (
        .mode     (PTR_REQ.mode),
        .ptr_cur  (ptr_cur),
        .disp     (PTR_REQ.disp),
        .eff_addr (eff_addr),
        .ptr_new  (ptr_new),
        .ptr_wr   (ptr_wr)
    );

    // stack step size and direction
    assign sp_step = (SP_OP == crf_pkg::CRF_SP_CALL || SP_OP == crf_pkg::CRF_SP_RET ||
                      SP_OP == crf_pkg::CRF_SP_IRQ_RETURN || IRQ_ACK) ? 16'h0002 : 16'h0001;
    assign sp_dn   = (SP_OP == crf_pkg::CRF_SP_PUSH) || (SP_OP == crf_pkg::CRF_SP_CALL) || IRQ_ACK;
    assign sp_up   = (SP_OP == crf_pkg::CRF_SP_POP) || (SP_OP == crf_pkg::CRF_SP_RET) ||
                     (SP_OP == crf_pkg::CRF_SP_IRQ_RETURN);

    // per source gate by own enable and global enable
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_NUM; gi++) begin : g_irq
            assign irq_live[gi] = IRQ_PEND[gi] & IRQ_EN[gi] & flags_r[`CRF_FLAG_I];
        end
    endgenerate
    assign irq_any = |irq_live;

    // lowest source wins, each has its own vector
    always_comb begin
        irq_idx = 16'h0000;
        for (int i = IRQ_NUM - 1; i >= 0; i--) begin
            if (irq_live[i]) begin
                irq_idx = 16'(i + 1);
            end
        end
    end

    // stack pointer next value, writes masked to implemented bits
    always_comb begin
        sp_nxt = sp_r;
        if (sp_dn) begin
            sp_nxt = (sp_r - sp_step) & SP_MASK;
        end else if (sp_up) begin
            sp_nxt = (sp_r + sp_step) & SP_MASK;
        end
        if (DS_WR && ds_sp_lo) begin
            sp_nxt = {sp_r[15:8], DS_WDATA} & SP_MASK;
        end
        if (DS_WR && ds_sp_hi) begin
            sp_nxt = {DS_WDATA, sp_r[7:0]} & SP_MASK;
        end
    end

    // flag next value; status is never pushed or popped here
    always_comb begin
        flags_nxt = flags_r;
        if (FLAG_IN.update_h) flags_nxt[`CRF_FLAG_H] = FLAG_IN.half;
        if (FLAG_IN.update_v) flags_nxt[`CRF_FLAG_V] = FLAG_IN.ovf;
        if (FLAG_IN.update_n) flags_nxt[`CRF_FLAG_N] = FLAG_IN.neg;
        if (FLAG_IN.update_z) flags_nxt[`CRF_FLAG_Z] = FLAG_IN.zero;
        if (FLAG_IN.update_c) flags_nxt[`CRF_FLAG_C] = FLAG_IN.carry;
        if (FLAG_T_WR) flags_nxt[`CRF_FLAG_T] = FLAG_T_VAL;
        if (DS_WR && ds_flags) flags_nxt = DS_WDATA;
        if (GIE_CLR) flags_nxt[`CRF_FLAG_I] = 1'b0;
        if (GIE_SET || SP_OP == crf_pkg::CRF_SP_IRQ_RETURN) flags_nxt[`CRF_FLAG_I] = 1'b1;
        if (IRQ_ACK) flags_nxt[`CRF_FLAG_I] = 1'b0;
        flags_nxt[`CRF_FLAG_S] = flags_nxt[`CRF_FLAG_N] ^ flags_nxt[`CRF_FLAG_V];
    end

    // working registers: alu result in same cycle, pointer and data writes
    always_ff @(posedge SYS_CLK) begin
        if (RF_REQ.wr_en && rf_wide_wr) begin
            regs_r[RF_REQ.wr_addr & 5'h1e] <= RF_REQ.wr_data[7:0];
            regs_r[rf_wr_hi]               <= RF_REQ.wr_data[15:8];
        end else if (RF_REQ.wr_en) begin
            regs_r[RF_REQ.wr_addr] <= RF_REQ.wr_data[7:0];
        end
        if (ptr_wr) begin
            regs_r[ptr_lo_idx]         <= ptr_new[7:0];
            regs_r[ptr_lo_idx | 5'h01] <= ptr_new[15:8];
        end
        if (DS_WR && ds_in_rf) begin
            regs_r[DS_ADDR[4:0]] <= DS_WDATA;
        end
    end

    // architectural state with reset
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sp_r    <= LAST_SRAM & SP_MASK;
            flags_r <= `CRF_FLAGS_RESET;
        end else begin
            sp_r    <= sp_nxt;
            flags_r <= flags_nxt;
        end
    end

    // operand and lookup outputs registered
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            opa_r      <= 16'h0000;
            opb_r      <= 8'h00;
            ds_rdata_r <= 8'h00;
            ds_hit_r   <= 1'b0;
            ptr_addr_r <= 16'h0000;
        end else begin
            opa_r      <= (RF_REQ.scheme == crf_pkg::CRF_ACC_R16W16) ?
                          {regs_r[rd_a_hi], regs_r[RF_REQ.rd_a & 5'h1e]} :
                          {8'h00, regs_r[RF_REQ.rd_a]};
            opb_r      <= (RF_REQ.scheme == crf_pkg::CRF_ACC_R1W1) ? 8'h00 : regs_r[RF_REQ.rd_b];
            ds_hit_r   <= (DS_RD || DS_WR) && (ds_in_rf || ds_sp_lo || ds_sp_hi || ds_flags);
            ds_rdata_r <= ds_in_rf ? regs_r[DS_ADDR[4:0]] :
                          ds_sp_lo ? sp_r[7:0] :
                          ds_sp_hi ? sp_r[15:8] :
                          ds_flags ? flags_r : 8'h00;
            ptr_addr_r <= eff_addr;
        end
    end

    // interrupt and pipeline registers
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_take_r <= 1'b0;
            irq_vec_r  <= `CRF_RESET_VECTOR;
            exec_r     <= 16'h0000;
        end else begin
            irq_take_r <= irq_any && !IRQ_ACK;
            irq_vec_r  <= irq_idx * `CRF_VECTOR_STEP;
            if (FETCH_VALID) begin
                exec_r <= FETCH_WORD;
            end
        end
    end

    // outputs straight from flip-flops
    assign RF_OPA     = opa_r;
    assign RF_OPB     = opb_r;
    assign PTR_ADDR   = ptr_addr_r;
    assign DS_RDATA   = ds_rdata_r;
    assign DS_HIT     = ds_hit_r;
    assign STACK_PTR  = sp_r;
    assign IRQ_TAKE   = irq_take_r;
    assign IRQ_VECTOR = irq_vec_r;
    assign FLAGS_OUT  = flags_r;
    assign EXEC_WORD  = exec_r;
endmodule

//--- crf_fetch_model.sv
// crf_fetch_model.sv: far-side instruction fetch, one new word every cycle
// assumes the same undivided SYS_CLK as the core state block
`timescale 1ns/100ps

module crf_fetch_model (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    output logic [15:0]      FETCH_WORD,
    output logic             FETCH_VALID
);
    // next word prefetched each cycle on the core clock, no division
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            FETCH_WORD  <= 16'h1000;
            FETCH_VALID <= 1'b0;
        end else begin
            FETCH_WORD  <= FETCH_WORD + 16'h0101;
            FETCH_VALID <= 1'b1;
        end
    end
endmodule

//--- crf_core_state_assertions.sv
// crf_core_state_assertions.sv: concurrent checks on the core state block ports
// assumes binding to crf_core_state; requests one per cycle on SYS_CLK
`timescale 1ns/100ps

module crf_core_state_chk #(
    parameter int          SP_BITS   = 11,
    parameter logic [15:0] LAST_SRAM = 16'h04ff,
    parameter int          IRQ_NUM   = 8
) (
    input wire logic                  SYS_CLK,
    input wire logic                  RST_B,
    input wire crf_pkg::crf_flag_in_t FLAG_IN,
    input wire logic                  DS_WR,
    input wire crf_pkg::crf_spop_t    SP_OP,
    input wire logic [15:0]           STACK_PTR,
    input wire logic [IRQ_NUM-1:0]    IRQ_PEND,
    input wire logic [IRQ_NUM-1:0]    IRQ_EN,
    input wire logic                  IRQ_ACK,
    input wire logic                  IRQ_TAKE,
    input wire logic [7:0]            FLAGS_OUT
);
    localparam logic [15:0] M = 16'((32'h1 << SP_BITS) - 1);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // flag bits, stack moves and interrupt gate
    a_sign_xor: assert property (FLAGS_OUT[4] == (FLAGS_OUT[2] ^ FLAGS_OUT[3]))
        else $error("sign bit wrong");
    a_half_load: assert property (FLAG_IN.update_h && !DS_WR |=> FLAGS_OUT[5] == $past(FLAG_IN.half))
        else $error("half carry not loaded");
    a_carry_load: assert property (FLAG_IN.update_c && !DS_WR |=> FLAGS_OUT[0] == $past(FLAG_IN.carry))
        else $error("carry not loaded");
    a_push_dec: assert property (SP_OP == crf_pkg::CRF_SP_PUSH && !DS_WR
        |=> STACK_PTR == (($past(STACK_PTR) - 16'h0001) & M)) else $error("push step wrong");
    a_pop_inc: assert property (SP_OP == crf_pkg::CRF_SP_POP && !DS_WR
        |=> STACK_PTR == (($past(STACK_PTR) + 16'h0001) & M)) else $error("pop step wrong");
    a_call_dec: assert property (SP_OP == crf_pkg::CRF_SP_CALL && !DS_WR
        |=> STACK_PTR == (($past(STACK_PTR) - 16'h0002) & M)) else $error("call step wrong");
    a_ret_inc: assert property ((SP_OP == crf_pkg::CRF_SP_RET || SP_OP == crf_pkg::CRF_SP_IRQ_RETURN) && !DS_WR
        |=> STACK_PTR == (($past(STACK_PTR) + 16'h0002) & M)) else $error("return step wrong");
    a_sp_upper: assert property ((STACK_PTR & ~M) == 16'h0000) else $error("unused stack bits set");
    a_sp_reset: assert property ($rose(RST_B) |-> STACK_PTR == (LAST_SRAM & M))
        else $error("stack reset wrong");
    a_gie_entry: assert property (IRQ_ACK |=> !FLAGS_OUT[7]) else $error("enable kept on entry");
    a_take_gate: assert property (IRQ_TAKE |-> $past(|(IRQ_PEND & IRQ_EN) && FLAGS_OUT[7]))
        else $error("take without enable");
endmodule

bind crf_core_state crf_core_state_chk #(.SP_BITS(SP_BITS), .LAST_SRAM(LAST_SRAM), .IRQ_NUM(IRQ_NUM)) u_chk (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .FLAG_IN(FLAG_IN), .DS_WR(DS_WR), .SP_OP(SP_OP),
    .STACK_PTR(STACK_PTR), .IRQ_PEND(IRQ_PEND), .IRQ_EN(IRQ_EN), .IRQ_ACK(IRQ_ACK),
    .IRQ_TAKE(IRQ_TAKE), .FLAGS_OUT(FLAGS_OUT));

//--- crf_core_state_tb.sv
// crf_core_state_tb.sv: directed tests of the core state block
// assumes the fetch model on the far side and the bound checker
`timescale 1ns/100ps

module crf_core_state_tb;
    logic                  SYS_CLK = 1'b0;
    logic                  RST_B = 1'b0;
    crf_pkg::crf_rf_req_t  RF_REQ = '{crf_pkg::CRF_ACC_R1W1, 1'b0, 5'h00, 5'h00, 5'h00, 16'h0000};
    crf_pkg::crf_flag_in_t FLAG_IN = '0;
    logic                  GIE_SET = 1'b0;
    logic                  GIE_CLR = 1'b0;
    crf_pkg::crf_ptr_req_t PTR_REQ = '{crf_pkg::CRF_PM_NONE, 2'h0, 6'h00};
    logic                  DS_WR = 1'b0;
    logic                  DS_RD = 1'b0;
    logic [15:0]           DS_ADDR = 16'h0000;
    logic [7:0]            DS_WDATA = 8'h00;
    crf_pkg::crf_spop_t    SP_OP = crf_pkg::CRF_SP_NONE;
    logic [7:0]            IRQ_PEND = 8'h00;
    logic [7:0]            IRQ_EN = 8'h00;
    logic                  IRQ_ACK = 1'b0;
    logic [15:0]           RF_OPA, PTR_ADDR, STACK_PTR, IRQ_VECTOR, FETCH_WORD, EXEC_WORD, exp, w;
    logic [7:0]            RF_OPB, DS_RDATA, FLAGS_OUT;
    logic                  DS_HIT, IRQ_TAKE, FETCH_VALID;
    int                    err_total = 0;
    int                    check_count = 0;
    int                    cyc_n = 0;
    crf_pkg::crf_spop_t    ops[5] = '{crf_pkg::CRF_SP_PUSH, crf_pkg::CRF_SP_POP, crf_pkg::CRF_SP_CALL,
                                      crf_pkg::CRF_SP_RET, crf_pkg::CRF_SP_IRQ_RETURN};
    int                    dl[5] = '{-1, 1, -2, 2, 2};

    crf_core_state dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .RF_REQ(RF_REQ), .RF_OPA(RF_OPA), .RF_OPB(RF_OPB),
        .FLAG_IN(FLAG_IN), .FLAG_T_WR(1'b0), .FLAG_T_VAL(1'b0), .GIE_SET(GIE_SET), .GIE_CLR(GIE_CLR),
        .PTR_REQ(PTR_REQ), .PTR_ADDR(PTR_ADDR), .DS_WR(DS_WR), .DS_RD(DS_RD), .DS_ADDR(DS_ADDR),
        .DS_WDATA(DS_WDATA), .DS_RDATA(DS_RDATA), .DS_HIT(DS_HIT), .SP_OP(SP_OP), .STACK_PTR(STACK_PTR),
        .IRQ_PEND(IRQ_PEND), .IRQ_EN(IRQ_EN), .IRQ_ACK(IRQ_ACK), .IRQ_TAKE(IRQ_TAKE), .IRQ_VECTOR(IRQ_VECTOR),
        .FLAGS_OUT(FLAGS_OUT), .FETCH_WORD(FETCH_WORD), .FETCH_VALID(FETCH_VALID), .EXEC_WORD(EXEC_WORD));
    crf_fetch_model u_fetch (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .FETCH_WORD(FETCH_WORD),
        .FETCH_VALID(FETCH_VALID));

    // 125 MHz clock and hang guard
    always #4 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask
    // drop all strobes after a one-cycle request, then let outputs settle
    task automatic idle;
        @(posedge SYS_CLK);
        DS_WR <= 1'b0;
        DS_RD <= 1'b0;
        SP_OP <= crf_pkg::CRF_SP_NONE;
        FLAG_IN <= '0;
        GIE_SET <= 1'b0;
        GIE_CLR <= 1'b0;
        IRQ_ACK <= 1'b0;
        PTR_REQ.mode <= crf_pkg::CRF_PM_NONE;
        RF_REQ.wr_en <= 1'b0;
        #1;
    endtask
    task automatic ds(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        DS_WR <= wr;
        DS_RD <= !wr;
        DS_ADDR <= a;
        DS_WDATA <= d;
        idle();
    endtask
    task automatic conclude;
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        idle();
        chk(STACK_PTR, 16'h04ff);
        chk(FLAGS_OUT, 16'h0000);
        ds(1'b0, 16'h005d, 8'h00);
        chk({DS_HIT, DS_RDATA}, 16'h01ff);
        ds(1'b0, 16'h005e, 8'h00);
        chk(DS_RDATA, 16'h0004);
        ds(1'b0, 16'h0040, 8'h00);
        chk({DS_HIT, DS_RDATA}, 16'h0000);
        for (int i = 0; i < 32; i++) ds(1'b1, 16'(i), 8'(i) ^ 8'ha5);
        for (int i = 0; i < 32; i++) begin
            ds(1'b0, 16'(i), 8'h00);
            chk(DS_RDATA, 16'(8'(i) ^ 8'ha5));
        end
        // wide write to the first pointer pair, then the R16W16, R2W1 and R1W1 read schemes
        @(posedge SYS_CLK) RF_REQ <= '{crf_pkg::CRF_ACC_R2W16, 1'b1, 5'h00, 5'h00, 5'h1b, 16'h0120};
        idle();
        @(posedge SYS_CLK) RF_REQ <= '{crf_pkg::CRF_ACC_R16W16, 1'b0, 5'h1a, 5'h00, 5'h00, 16'h0000};
        idle();
        chk(RF_OPA, 16'h0120);
        @(posedge SYS_CLK) RF_REQ <= '{crf_pkg::CRF_ACC_R2W1, 1'b0, 5'h1a, 5'h1b, 5'h00, 16'h0000};
        idle();
        chk({RF_OPA[7:0], RF_OPB}, 16'h2001);
        @(posedge SYS_CLK) RF_REQ <= '{crf_pkg::CRF_ACC_R1W1, 1'b1, 5'h1b, 5'h00, 5'h05, 16'h003c};
        idle();
        chk({RF_OPA[7:0], RF_OPB}, 16'h0100);
        ds(1'b0, 16'h0005, 8'h00);
        chk(DS_RDATA, 16'h003c);
        // pointer modes on the first pair
        @(posedge SYS_CLK) PTR_REQ <= '{crf_pkg::CRF_PM_INC, 2'h0, 6'h00};
        idle();
        chk(PTR_ADDR, 16'h0120);
        ds(1'b0, 16'h001a, 8'h00);
        chk(DS_RDATA, 16'h0021);
        @(posedge SYS_CLK) PTR_REQ <= '{crf_pkg::CRF_PM_DEC, 2'h0, 6'h00};
        idle();
        chk(PTR_ADDR, 16'h0120);
        @(posedge SYS_CLK) PTR_REQ <= '{crf_pkg::CRF_PM_DISP, 2'h0, 6'h05};
        idle();
        chk(PTR_ADDR, 16'h0125);
        // second and third pairs take their bytes from 0x1c and 0x1e
        @(posedge SYS_CLK) PTR_REQ <= '{crf_pkg::CRF_PM_DISP, 2'h2, 6'h01};
        idle();
        chk(PTR_ADDR, 16'hbabc);
        @(posedge SYS_CLK) PTR_REQ <= '{crf_pkg::CRF_PM_DEC, 2'h1, 6'h00};
        idle();
        chk(PTR_ADDR, 16'hb8b8);
        // flag loads, partial update and the derived sign
        @(posedge SYS_CLK) FLAG_IN <= 10'h3f9;
        idle();
        chk(FLAGS_OUT, 16'h0039);
        @(posedge SYS_CLK) FLAG_IN <= 10'h3e6;
        idle();
        chk(FLAGS_OUT, 16'h0016);
        @(posedge SYS_CLK) FLAG_IN <= 10'h021;
        idle();
        chk(FLAGS_OUT, 16'h0017);
        // stack placed before any call, then masked high byte
        ds(1'b1, 16'h005d, 8'h80);
        ds(1'b1, 16'h005e, 8'hff);
        chk(STACK_PTR, 16'h0780);
        ds(1'b0, 16'h005e, 8'h00);
        chk(DS_RDATA, 16'h0007);
        ds(1'b1, 16'h005e, 8'h03);
        exp = 16'h0380;
        for (int i = 0; i < 5; i++) begin
            @(posedge SYS_CLK) SP_OP <= ops[i];
            idle();
            exp = exp + 16'(dl[i]);
            chk(STACK_PTR, exp);
        end
        chk(FLAGS_OUT, 16'h0097);
        // interrupt gate, priority vector, entry and no flag save
        @(posedge SYS_CLK) GIE_CLR <= 1'b1;
        IRQ_PEND <= 8'h24;
        IRQ_EN <= 8'h24;
        idle();
        idle();
        chk(IRQ_TAKE, 16'h0000);
        @(posedge SYS_CLK) GIE_SET <= 1'b1;
        IRQ_EN <= 8'h00;
        idle();
        idle();
        chk(IRQ_TAKE, 16'h0000);
        @(posedge SYS_CLK) IRQ_EN <= 8'h20;
        idle();
        idle();
        chk({IRQ_TAKE, IRQ_VECTOR[14:0]}, 16'h800c);
        @(posedge SYS_CLK) IRQ_EN <= 8'h24;
        idle();
        idle();
        chk({IRQ_TAKE, IRQ_VECTOR[14:0]}, 16'h8006);
        @(posedge SYS_CLK) IRQ_ACK <= 1'b1;
        idle();
        chk(FLAGS_OUT, 16'h0017);
        chk(STACK_PTR, 16'h0380);
        // prefetched word reaches execute one cycle later
        @(posedge SYS_CLK) #1 w = FETCH_WORD;
        @(posedge SYS_CLK) #1 chk(EXEC_WORD, w);
        conclude();
    end
endmodule
